// >>> hdl/cgc_pkg.sv
// Purpose: Shared constants and types for the clock generator config port
// Assumes: 100 MHz core clock
// Notes: Timing counts derive from times in their own units
package cgc_pkg;

	// Register space and stored configurations
	localparam int REG_COUNT = 16;
	localparam int IDX_W = 4;
	localparam int CFG_COUNT = 4;

	// Synchronised pin positions
	localparam int PIN_W = 4;
	localparam int PIN_SCL = 0;
	localparam int PIN_SDA = 1;
	localparam int PIN_SEL_LO = 2;
	localparam int PIN_SEL_HI = 3;

	// Slave addresses, 8-bit form with the direction bit clear
	localparam logic [7:0] DEV_ADDR_DEFAULT = 8'hd4;
	localparam logic [7:0] DEV_ADDR_ALT = 8'hd0;
	localparam int ADDR_SEL_REG = 0;
	localparam int ADDR_SEL_BIT = 0;

	// Command codes sent as the single byte of a two-byte write
	localparam logic [7:0] CMD_SAVE = 8'hf0;
	localparam logic [7:0] CMD_RESTORE = 8'hf1;
	localparam logic [7:0] CMD_SYNC = 8'hf2;

	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int POR_TIME_MS = 10;
	localparam int POR_CYCLES = POR_TIME_MS * 1000000 / CLK_PERIOD_NS;
	localparam int EXEC_TIME_US = 100;
	localparam int EXEC_CYCLES = EXEC_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int CNT_W = 24;

	// Reset values
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [PIN_W-1:0] PIN_RESET = 4'h0;

	typedef logic [REG_COUNT-1:0][7:0] cgc_bank_t;
	typedef cgc_bank_t [CFG_COUNT-1:0] cgc_otp_t;

	typedef enum logic [1:0] {ST_POR, ST_LOAD, ST_RUN, ST_EXEC} cgc_mode_t;
	typedef enum logic [2:0] {PH_IDLE, PH_RX, PH_ACK, PH_TX, PH_RACK} cgc_phase_t;

	typedef struct packed {
		logic [PIN_W-1:0] s1;
		logic [PIN_W-1:0] s2;
		logic [PIN_W-1:0] s3;
		logic [PIN_W-1:0] q;
	} cgc_pin_t;

	typedef struct packed {
		logic ready;
		logic div_sync;
		logic otp_burn;
		logic [1:0] burn_bank;
	} cgc_status_t;

	typedef struct packed {
		cgc_mode_t mode;
		cgc_phase_t phase;
		logic [CNT_W-1:0] cnt;
		logic [3:0] bit_cnt;
		logic [7:0] shift;
		logic [1:0] byte_idx;
		logic rw;
		logic matched;
		logic [15:0] ptr;
		logic [7:0] cmd;
		logic [7:0] exec_cmd;
		logic [1:0] cfg_sel;
		logic prev_scl;
		logic prev_sda;
		logic sda_oe;
		logic div_sync;
		logic otp_burn;
		cgc_bank_t regs;
		cgc_bank_t wbuf;
		logic [REG_COUNT-1:0] wmask;
	} cgc_state_t;

endpackage

// >>> hdl/cgc_pin_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for pin inputs
// Assumes: Pins are asynchronous to clock
// Notes: Output changes only once stages two and three agree
`timescale 1ns/10ps

module cgc_pin_sync #(
	parameter int WIDTH = cgc_pkg::PIN_W
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	// Pins and filtered levels
	input wire logic [WIDTH-1:0] pins_in,
	output logic [WIDTH-1:0] pins_q
);

	generate
		if (WIDTH != cgc_pkg::PIN_W) begin : g_chk
			$error("cgc_pin_sync width must match the package pin count");
		end
	endgenerate

	cgc_pkg::cgc_pin_t s_ff;
	cgc_pkg::cgc_pin_t nxt_s;

	always_comb begin
		nxt_s = s_ff;
		nxt_s.s1 = pins_in;
		// First stage feeds only the second
		nxt_s.s2 = s_ff.s1;
		nxt_s.s3 = s_ff.s2;
		nxt_s.q = ((s_ff.s2 ~^ s_ff.s3) & s_ff.s3) | ((s_ff.s2 ^ s_ff.s3) & s_ff.q);
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_ff <= '{s1: cgc_pkg::PIN_RESET, s2: cgc_pkg::PIN_RESET,
				s3: cgc_pkg::PIN_RESET, q: cgc_pkg::PIN_RESET};
		end else if (ce) begin
			s_ff <= nxt_s;
		end
	end

	assign pins_q = s_ff.q;

endmodule

// >>> hdl/cgc_config_port.sv
// Purpose: Serial configuration port and start-up loader of a clock generator
// Assumes: Serial pins arrive asynchronously; open-drain data pin
// Notes: Bus pins sampled at 100 MHz, far above the serial clock
//
// Operation
// - Answer one of two 8-bit slave addresses
// - Default high address, select bit picks low
// - Byte-wise block write and block read
// - Address bytes set the start register
// - Successive bytes, rising addresses, MSB first
// - Block may end after any byte
// - Buffer writes, commit all at STOP
// - Write sequence; acknowledge every received byte
// - Read: master acks all but last byte
// - No acknowledges while command executes
// - Power-up reset lasts at most 10 ms
// - After power-up reset, load stored configuration
// - Silent on serial port until loaded
// - Ready shown by acknowledging own address
// - Four stored configurations, one selected
// - Serial writes may overwrite loaded registers
// - Reset discards serial writes, reloads stored
// - Sync pulse to dividers, also by command
`timescale 1ns/10ps

module cgc_config_port #(
	parameter int POR_CYCLES = cgc_pkg::POR_CYCLES,
	parameter int EXEC_CYCLES = cgc_pkg::EXEC_CYCLES
) (
	// Clock, reset, enable
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	// Serial bus
	input wire logic scl,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	// Configuration select pins
	input wire logic config_select_low_pin,
	input wire logic config_select_high_pin,
	// Stored configurations
	input wire cgc_pkg::cgc_otp_t otp_image,
	// Live configuration and status
	output cgc_pkg::cgc_bank_t cfg_regs,
	output cgc_pkg::cgc_status_t status
);

	generate
		if (POR_CYCLES < 1 || POR_CYCLES >= (1 << cgc_pkg::CNT_W)) begin : g_chk_por
			$error("POR_CYCLES outside counter range");
		end
		if (EXEC_CYCLES < 1 || EXEC_CYCLES >= (1 << cgc_pkg::CNT_W)) begin : g_chk_exec
			$error("EXEC_CYCLES outside counter range");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////

	localparam logic [cgc_pkg::CNT_W-1:0] POR_LAST = cgc_pkg::CNT_W'(POR_CYCLES - 1);
	localparam logic [cgc_pkg::CNT_W-1:0] EXEC_LAST = cgc_pkg::CNT_W'(EXEC_CYCLES - 1);
	localparam logic [15:0] REG_LIMIT = 16'(cgc_pkg::REG_COUNT);

	function automatic logic [7:0] dev_addr(input cgc_pkg::cgc_bank_t bank);
		logic [7:0] a;
		a = cgc_pkg::DEV_ADDR_DEFAULT;
		if (bank[cgc_pkg::ADDR_SEL_REG][cgc_pkg::ADDR_SEL_BIT]) begin
			a = cgc_pkg::DEV_ADDR_ALT;
		end
		return a;
	endfunction

	function automatic logic [7:0] rd_byte(input cgc_pkg::cgc_bank_t bank, input logic [15:0] p);
		logic [7:0] b;
		b = 8'h00;
		if (p < REG_LIMIT) begin
			b = bank[p[cgc_pkg::IDX_W-1:0]];
		end
		return b;
	endfunction

	function automatic logic is_cmd(input logic [7:0] c);
		return c == cgc_pkg::CMD_SAVE || c == cgc_pkg::CMD_RESTORE || c == cgc_pkg::CMD_SYNC;
	endfunction

	////////////////////////////////////////////////////////////////////////////////

	cgc_pkg::cgc_state_t s_ff;
	cgc_pkg::cgc_state_t nxt_s;
	logic [cgc_pkg::PIN_W-1:0] pin_q;
	logic bus_scl;
	logic bus_sda;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic ready;
	logic [7:0] my_addr;
	logic [1:0] sel_now;

	cgc_pin_sync #(
		.WIDTH(cgc_pkg::PIN_W)
	) u_pin_sync (
		.clock(clock),
		.rst(rst),
		.ce(ce),
		.pins_in({config_select_high_pin, config_select_low_pin, sda_i, scl}),
		.pins_q(pin_q)
	);

	assign bus_scl = pin_q[cgc_pkg::PIN_SCL];
	assign bus_sda = pin_q[cgc_pkg::PIN_SDA];
	assign sel_now = {pin_q[cgc_pkg::PIN_SEL_HI], pin_q[cgc_pkg::PIN_SEL_LO]};
	assign scl_rise = bus_scl & ~s_ff.prev_scl;
	assign scl_fall = ~bus_scl & s_ff.prev_scl;
	assign bus_start = bus_scl & s_ff.prev_scl & ~bus_sda & s_ff.prev_sda;
	assign bus_stop = bus_scl & s_ff.prev_scl & bus_sda & ~s_ff.prev_sda;
	assign ready = s_ff.mode == cgc_pkg::ST_RUN;
	assign my_addr = dev_addr(s_ff.regs);

	////////////////////////////////////////////////////////////////////////////////

	always_comb begin
		nxt_s = s_ff;
		nxt_s.div_sync = 1'b0;
		nxt_s.otp_burn = 1'b0;
		nxt_s.prev_scl = bus_scl;
		nxt_s.prev_sda = bus_sda;

		// Start-up and command sequencing
		case (s_ff.mode)
			cgc_pkg::ST_POR: begin
				if (s_ff.cnt == POR_LAST) begin
					nxt_s.mode = cgc_pkg::ST_LOAD;
					nxt_s.cnt = '0;
				end else begin
					nxt_s.cnt = s_ff.cnt + 1'b1;
				end
			end
			cgc_pkg::ST_LOAD: begin
				nxt_s.cfg_sel = sel_now;
				nxt_s.regs = otp_image[sel_now];
				nxt_s.div_sync = 1'b1;
				nxt_s.mode = cgc_pkg::ST_RUN;
			end
			cgc_pkg::ST_EXEC: begin
				if (s_ff.cnt == EXEC_LAST) begin
					nxt_s.mode = cgc_pkg::ST_RUN;
					nxt_s.cnt = '0;
					if (s_ff.exec_cmd == cgc_pkg::CMD_RESTORE) begin
						nxt_s.regs = otp_image[s_ff.cfg_sel];
					end else if (s_ff.exec_cmd == cgc_pkg::CMD_SAVE) begin
						nxt_s.otp_burn = 1'b1;
					end else begin
						nxt_s.div_sync = 1'b1;
					end
				end else begin
					nxt_s.cnt = s_ff.cnt + 1'b1;
				end
			end
			default: begin
			end
		endcase

		// Serial bus; tracked always, answered only when ready
		if (bus_start) begin
			nxt_s.phase = cgc_pkg::PH_RX;
			nxt_s.bit_cnt = 4'h0;
			nxt_s.byte_idx = 2'h0;
			nxt_s.sda_oe = 1'b0;
		end else if (bus_stop) begin
			nxt_s.phase = cgc_pkg::PH_IDLE;
			nxt_s.sda_oe = 1'b0;
			if (s_ff.matched && !s_ff.rw && ready) begin
				if (s_ff.byte_idx == 2'h2 && is_cmd(s_ff.cmd)) begin
					nxt_s.mode = cgc_pkg::ST_EXEC;
					nxt_s.exec_cmd = s_ff.cmd;
					nxt_s.cnt = '0;
				end else begin
					for (int i = 0; i < cgc_pkg::REG_COUNT; i++) begin
						if (s_ff.wmask[i]) begin
							nxt_s.regs[i] = s_ff.wbuf[i];
						end
					end
				end
			end
			nxt_s.wmask = '0;
			nxt_s.matched = 1'b0;
		end else begin
			case (s_ff.phase)
				cgc_pkg::PH_RX: begin
					if (scl_rise) begin
						nxt_s.shift = {s_ff.shift[6:0], bus_sda};
						nxt_s.bit_cnt = s_ff.bit_cnt + 4'h1;
					end else if (scl_fall && s_ff.bit_cnt == 4'h8) begin
						nxt_s.bit_cnt = 4'h0;
						nxt_s.phase = cgc_pkg::PH_ACK;
						nxt_s.sda_oe = 1'b1;
						if (s_ff.byte_idx != 2'h3) begin
							nxt_s.byte_idx = s_ff.byte_idx + 2'h1;
						end
						if (s_ff.byte_idx == 2'h0) begin
							nxt_s.rw = s_ff.shift[0];
							nxt_s.matched = ready && s_ff.shift[7:1] == my_addr[7:1];
							if (!(ready && s_ff.shift[7:1] == my_addr[7:1])) begin
								nxt_s.sda_oe = 1'b0;
								nxt_s.phase = cgc_pkg::PH_IDLE;
							end
						end else if (s_ff.byte_idx == 2'h1) begin
							nxt_s.ptr[15:8] = s_ff.shift;
							nxt_s.cmd = s_ff.shift;
						end else if (s_ff.byte_idx == 2'h2) begin
							nxt_s.ptr[7:0] = s_ff.shift;
						end else begin
							if (s_ff.ptr < REG_LIMIT) begin
								nxt_s.wbuf[s_ff.ptr[cgc_pkg::IDX_W-1:0]] = s_ff.shift;
								nxt_s.wmask[s_ff.ptr[cgc_pkg::IDX_W-1:0]] = 1'b1;
							end
							nxt_s.ptr = s_ff.ptr + 16'h1;
						end
					end
				end
				cgc_pkg::PH_ACK: begin
					if (scl_fall) begin
						if (s_ff.rw) begin
							// Read starts at pointer, set or left over
							nxt_s.shift = rd_byte(s_ff.regs, s_ff.ptr);
							nxt_s.ptr = s_ff.ptr + 16'h1;
							nxt_s.sda_oe = ~nxt_s.shift[7];
							nxt_s.bit_cnt = 4'h0;
							nxt_s.phase = cgc_pkg::PH_TX;
						end else begin
							nxt_s.sda_oe = 1'b0;
							nxt_s.phase = cgc_pkg::PH_RX;
						end
					end
				end
				cgc_pkg::PH_TX: begin
					if (scl_fall) begin
						if (s_ff.bit_cnt == 4'h7) begin
							nxt_s.sda_oe = 1'b0;
							nxt_s.bit_cnt = 4'h0;
							nxt_s.phase = cgc_pkg::PH_RACK;
						end else begin
							nxt_s.shift = {s_ff.shift[6:0], 1'b0};
							nxt_s.sda_oe = ~s_ff.shift[6];
							nxt_s.bit_cnt = s_ff.bit_cnt + 4'h1;
						end
					end
				end
				cgc_pkg::PH_RACK: begin
					if (scl_rise) begin
						// Not acknowledged ends the read quietly
						nxt_s.phase = bus_sda ? cgc_pkg::PH_IDLE : cgc_pkg::PH_ACK;
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_ff <= '0;
			s_ff.mode <= cgc_pkg::ST_POR;
			s_ff.phase <= cgc_pkg::PH_IDLE;
		end else if (ce) begin
			s_ff <= nxt_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	assign sda_o = 1'b0;
	assign sda_oe = s_ff.sda_oe;
	assign cfg_regs = s_ff.regs;
	assign status = '{ready: ready, div_sync: s_ff.div_sync, otp_burn: s_ff.otp_burn,
		burn_bank: s_ff.cfg_sel};

	AST_POR_EXPIRE: assert property (@(posedge clock) disable iff (rst)
		(ce && s_ff.mode == cgc_pkg::ST_POR && s_ff.cnt == POR_LAST)
		|=> s_ff.mode == cgc_pkg::ST_LOAD)
		else $error("power-up reset did not expire on time");

	AST_LOAD_RUN: assert property (@(posedge clock) disable iff (rst)
		(ce && s_ff.mode == cgc_pkg::ST_LOAD)
		|=> s_ff.mode == cgc_pkg::ST_RUN && s_ff.div_sync && s_ff.regs == otp_image[s_ff.cfg_sel])
		else $error("stored configuration not loaded");

	AST_SILENT: assert property (@(posedge clock) disable iff (rst)
		(s_ff.mode != cgc_pkg::ST_RUN) |-> !s_ff.sda_oe)
		else $error("data pin driven while not ready");

	AST_ADDR_ACK: assert property (@(posedge clock) disable iff (rst)
		(ce && !bus_start && !bus_stop && scl_fall && s_ff.phase == cgc_pkg::PH_RX
		&& s_ff.bit_cnt == 4'h8 && s_ff.byte_idx == 2'h0 && ready
		&& s_ff.shift[7:1] == my_addr[7:1]) |=> s_ff.sda_oe && s_ff.matched)
		else $error("own address not acknowledged");

	AST_ADDR_MISS: assert property (@(posedge clock) disable iff (rst)
		(ce && !bus_start && !bus_stop && scl_fall && s_ff.phase == cgc_pkg::PH_RX
		&& s_ff.bit_cnt == 4'h8 && s_ff.byte_idx == 2'h0
		&& s_ff.shift[7:1] != my_addr[7:1]) |=> !s_ff.sda_oe && s_ff.phase == cgc_pkg::PH_IDLE)
		else $error("foreign address acknowledged");

	AST_HOLD_REGS: assert property (@(posedge clock) disable iff (rst)
		(ce && !bus_stop && s_ff.mode == cgc_pkg::ST_RUN) |=> $stable(s_ff.regs))
		else $error("registers changed before stop");

	AST_COMMIT: assert property (@(posedge clock) disable iff (rst)
		(ce && bus_stop && ready && s_ff.matched && !s_ff.rw && s_ff.wmask[0]
		&& !(s_ff.byte_idx == 2'h2 && is_cmd(s_ff.cmd)))
		|=> s_ff.regs[0] == $past(s_ff.wbuf[0]) && s_ff.wmask == '0)
		else $error("buffered write not committed at stop");

	AST_PTR_STEP: assert property (@(posedge clock) disable iff (rst)
		(ce && !bus_start && !bus_stop && scl_fall && s_ff.phase == cgc_pkg::PH_ACK && s_ff.rw)
		|=> s_ff.ptr == $past(s_ff.ptr) + 16'h1 && s_ff.phase == cgc_pkg::PH_TX)
		else $error("read pointer did not advance");

	AST_NACK_END: assert property (@(posedge clock) disable iff (rst)
		(ce && !bus_start && !bus_stop && scl_rise && bus_sda && s_ff.phase == cgc_pkg::PH_RACK)
		|=> s_ff.phase == cgc_pkg::PH_IDLE ##1 !s_ff.sda_oe)
		else $error("read continued after missing acknowledge");

	AST_EXEC_QUIET: assert property (@(posedge clock) disable iff (rst)
		(s_ff.mode == cgc_pkg::ST_EXEC) |-> !s_ff.sda_oe && !s_ff.matched)
		else $error("acknowledge during command execution");

endmodule

// >>> test/cgc_i2c_master.sv
// Purpose: Serial bus master model for the config port
// Assumes: Open-drain data line, pull-up resolved by the bench
// Notes: 250-cycle bit period, 400 kHz at 100 MHz
`timescale 1ns/10ps

module cgc_i2c_master #(
	parameter int T_LOW = 130,
	parameter int T_HIGH = 120
) (
	// Clock
	input wire logic clock,
	// Bus
	input wire logic sda_line,
	output logic scl,
	output logic sda_low
);

	// Idle bus: clock parked high, data released
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic wt(input int n);
		repeat (n) @(posedge clock);
	endtask

	// Also serves as repeated start
	task automatic start_cond();
		sda_low <= 1'b0;
		wt(T_LOW / 2);
		scl <= 1'b1;
		wt(T_HIGH);
		sda_low <= 1'b1;
		wt(T_HIGH);
		scl <= 1'b0;
		wt(T_LOW / 2);
	endtask

	task automatic stop_cond();
		sda_low <= 1'b1;
		wt(T_LOW / 2);
		scl <= 1'b1;
		wt(T_HIGH);
		sda_low <= 1'b0;
		wt(T_HIGH * 2);
	endtask

	// Data moves only while clock is low; sampled mid-high
	task automatic bit_io(input logic b, output logic r);
		sda_low <= ~b;
		wt(T_LOW / 2);
		scl <= 1'b1;
		wt(T_HIGH / 2);
		r = sda_line;
		wt(T_HIGH / 2);
		scl <= 1'b0;
		wt(T_LOW / 2);
	endtask

	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, r);
		ack = ~r;
	endtask

	// Last byte of a read left unacknowledged
	task automatic rd_byte(input logic more, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(~more, r);
	endtask

endmodule

// >>> test/tb_cgc_config_port.sv
// Purpose: Self-checking bench for the config port
// Assumes: Pull-up on data line, pins static during load
// Notes: Short power-up and command times keep the run brief
`timescale 1ns/10ps

module tb_cgc_config_port;
	localparam int POR_N = 4000;
	localparam int EXEC_N = 4000;
	localparam int LIMIT = 100000;

	logic clock;
	logic rst;
	logic ce;
	logic scl;
	logic sda_low;
	logic sda_o;
	logic sda_oe;
	logic sel_lo;
	logic sel_hi;
	wire sda_line;
	cgc_pkg::cgc_otp_t otp;
	cgc_pkg::cgc_bank_t cfg_regs;
	cgc_pkg::cgc_bank_t exp_regs;
	cgc_pkg::cgc_status_t status;
	int fails;
	int total_checks;
	int seed;
	int cyc;
	int por_cnt;
	int burns;
	int syncs;
	int acks;
	logic [1:0] burn_sel;
	logic [7:0] dev;
	logic [7:0] tx_q[$];
	logic [7:0] rx_q[$];
	logic [7:0] cmds[3] = '{cgc_pkg::CMD_SAVE, cgc_pkg::CMD_SYNC, cgc_pkg::CMD_RESTORE};

	// Open drain: either party pulls low
	assign sda_line = ~(sda_low | (sda_oe & ~sda_o));

	initial clock = 1'b0;
	always #5 clock = ~clock;

	cgc_config_port #(.POR_CYCLES(POR_N), .EXEC_CYCLES(EXEC_N)) u_dut (
		.clock(clock), .rst(rst), .ce(ce), .scl(scl), .sda_i(sda_line),
		.sda_o(sda_o), .sda_oe(sda_oe), .config_select_low_pin(sel_lo),
		.config_select_high_pin(sel_hi), .otp_image(otp), .cfg_regs(cfg_regs),
		.status(status)
	);

	cgc_i2c_master u_mst (.clock(clock), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));

	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clock) begin
		cyc <= cyc + 1;
		por_cnt <= rst ? 0 : (status.ready ? por_cnt : por_cnt + 1);
		if (status.otp_burn === 1'b1) begin
			burns <= burns + 1;
			burn_sel <= status.burn_bank;
		end
		if (status.div_sync === 1'b1)
			syncs <= syncs + 1;
		if (cyc == LIMIT) begin
			fails = fails + 1;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input string name, input logic [127:0] seen, input logic [127:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	function automatic logic [7:0] addr_now(input cgc_pkg::cgc_bank_t r);
		return r[cgc_pkg::ADDR_SEL_REG][cgc_pkg::ADDR_SEL_BIT] ?
			cgc_pkg::DEV_ADDR_ALT : cgc_pkg::DEV_ADDR_DEFAULT;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	task automatic send_w(input logic [7:0] d, input logic fin);
		logic a;
		acks = 0;
		u_mst.start_cond();
		u_mst.wr_byte(d, a);
		acks += int'(a === 1'b1);
		foreach (tx_q[i]) begin
			u_mst.wr_byte(tx_q[i], a);
			acks += int'(a === 1'b1);
		end
		if (fin)
			u_mst.stop_cond();
	endtask

	task automatic send_r(input logic [7:0] d, input logic use_ptr, input logic [15:0] p,
			input int n);
		logic a;
		logic [7:0] b;
		rx_q = {};
		acks = 0;
		u_mst.start_cond();
		if (use_ptr) begin
			u_mst.wr_byte(d, a);
			u_mst.wr_byte(p[15:8], a);
			u_mst.wr_byte(p[7:0], a);
			u_mst.start_cond();
		end
		u_mst.wr_byte(d | 8'h01, a);
		acks += int'(a === 1'b1);
		for (int i = 0; i < n; i++) begin
			u_mst.rd_byte(i < n - 1, b);
			rx_q.push_back(b);
		end
		u_mst.stop_cond();
	endtask

	// Bounded; command and power-up waits are both short here
	task automatic wait_ready();
		int k;
		k = 0;
		while (status.ready !== 1'b1 && k < POR_N + EXEC_N) begin
			@(posedge clock);
			k++;
		end
		// One more edge so the monitor's pulse counts have landed
		@(posedge clock);
		chk("ready", status.ready, 1'b1);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [15:0] ptr;
		logic [7:0] d0;
		logic [7:0] d1;
		int b0;
		int s0;
		seed = 73;
		cyc = 0;
		fails = 0;
		total_checks = 0;
		burns = 0;
		syncs = 0;
		por_cnt = 0;
		burn_sel = 2'h0;
		ce = 1'b1;
		rst = 1'b1;
		{sel_hi, sel_lo} = 2'($random(seed));
		// Address select bit cleared so start-up address is the default
		for (int k = 0; k < cgc_pkg::CFG_COUNT; k++) begin
			for (int r = 0; r < cgc_pkg::REG_COUNT; r++)
				otp[k][r] = 8'($random(seed)) & (r == 0 ? 8'hfe : 8'hff);
		end
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		tx_q = {};
		send_w(cgc_pkg::DEV_ADDR_DEFAULT, 1'b1);
		chk("early_acks", acks, 0);
		wait_ready();
		chk("por_len", por_cnt >= POR_N && por_cnt <= POR_N + 4, 1'b1);
		exp_regs = otp[{sel_hi, sel_lo}];
		chk("load", cfg_regs, exp_regs);
		chk("load_sync", syncs, 1);
		dev = addr_now(exp_regs);
		$display("test power_up done");

		send_w(cgc_pkg::DEV_ADDR_ALT, 1'b1);
		chk("other_addr", acks, 0);
		$display("test foreign_address done");

		ptr = 16'(1 + ($unsigned($random(seed)) % 12));
		d0 = 8'($random(seed));
		d1 = 8'($random(seed));
		tx_q = {ptr[15:8], ptr[7:0], d0, d1};
		send_w(dev, 1'b0);
		chk("write_acks", acks, 5);
		chk("held", cfg_regs, exp_regs);
		u_mst.stop_cond();
		exp_regs[ptr[3:0]] = d0;
		exp_regs[ptr[3:0] + 4'h1] = d1;
		chk("commit", cfg_regs, exp_regs);
		send_r(dev, 1'b0, 16'h0000, 1);
		chk("cur_read", rx_q[0], exp_regs[ptr[3:0] + 4'h2]);
		send_r(dev, 1'b1, ptr, 2);
		chk("rd0", rx_q[0], d0);
		chk("rd1", rx_q[1], d1);
		$display("test write_read done");

		tx_q = {8'h00, 8'h00, 8'h01};
		send_w(dev, 1'b1);
		exp_regs[0] = 8'h01;
		tx_q = {};
		send_w(cgc_pkg::DEV_ADDR_DEFAULT, 1'b1);
		chk("old_addr", acks, 0);
		send_w(cgc_pkg::DEV_ADDR_ALT, 1'b1);
		chk("new_addr", acks, 1);
		dev = addr_now(exp_regs);
		$display("test address_select done");

		foreach (cmds[c]) begin
			b0 = burns;
			s0 = syncs;
			tx_q = {cmds[c]};
			send_w(dev, 1'b1);
			chk("cmd_acks", acks, 2);
			tx_q = {};
			send_w(dev, 1'b1);
			chk("busy_nack", acks, 0);
			wait_ready();
			if (cmds[c] == cgc_pkg::CMD_SAVE) begin
				chk("burns", burns, b0 + 1);
				chk("burn_bank", burn_sel, {sel_hi, sel_lo});
			end
			if (cmds[c] == cgc_pkg::CMD_SYNC)
				chk("syncs", syncs, s0 + 1);
			if (cmds[c] == cgc_pkg::CMD_RESTORE)
				exp_regs = otp[{sel_hi, sel_lo}];
			chk("cmd_regs", cfg_regs, exp_regs);
			dev = addr_now(exp_regs);
		end
		$display("test commands done");

		{sel_hi, sel_lo} <= {sel_hi, sel_lo} + 2'h1;
		rst <= 1'b1;
		repeat (10) @(posedge clock);
		chk("rst_clear", cfg_regs, '0);
		rst <= 1'b0;
		// Enable low for 50 edges must stretch the power-up count by 50
		repeat (100) @(posedge clock);
		ce <= 1'b0;
		repeat (50) @(posedge clock);
		ce <= 1'b1;
		wait_ready();
		chk("por_len2", por_cnt >= POR_N + 50 && por_cnt <= POR_N + 54, 1'b1);
		chk("reload", cfg_regs, otp[{sel_hi, sel_lo}]);
		$display("test mid_reset done");
		stop_test();
	end

endmodule
